/* rtl/mcu_address_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Low window at zero maps to flash when alias select is 0; when 1, only its first 8 kB map to SRAM.
// - Software writing the alias select moves SRAM into the low window.
// - After reset the alias select shows flash at address zero.
// - Unused or reserved addresses get an error from the default slave.
// - Flash is 96 kB and SRAM 8 kB, each decoded as its own slave.
// - E000_0000 to E00F_FFFF goes to the private peripheral bus.
// - 4000_1C00 to 4000_1FFF goes to the shared serial peripheral group.
// - One non-maskable and nine numbered interrupt lines are given.
// - Flash controller interrupt drives line 0.
// - External interrupt from the system basis chip drives line 1.
// - The 32-bit timer interrupt drives line 4.
module mcu_address_decoder (
  // Clock, reset, enable
  input  wire logic                 CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic                 CE_I,
  // Master address phase
  input  wire logic [31:0]          HADDR_I,
  input  wire logic [1:0]           HTRANS_I,
  input  wire logic                 HREADY_I,
  // Alias select write strobe from the port configuration register
  input  wire logic                 ALIAS_WR_I,
  input  wire logic                 ALIAS_VAL_I,
  // Slave answers, one per slave
  input  wire logic [11:0]          SLV_READY_I,
  input  wire logic [11:0]          SLV_RESP_I,
  input  wire logic [31:0]          SLV_RDATA_I [12],
  // Slave selects and remapped address
  output logic      [11:0]          SLV_SEL_O,
  output logic      [31:0]          SLV_ADDR_O,
  // Answer to master
  output logic                      HREADY_O,
  output logic                      HRESP_O,
  output logic      [31:0]          HRDATA_O,
  output logic                      ALIAS_SEL_O,
  // Interrupt sources
  input  wire logic                 FLASH_IRQ_I,
  input  wire logic                 SBC_IRQ_I,
  input  wire logic                 LIN_IRQ_I,
  input  wire logic                 SPI_IRQ_I,
  input  wire logic                 TMR_IRQ_I,
  input  wire logic                 GPIO_IRQ_I,
  input  wire logic                 SSPI_IRQ_I,
  input  wire logic                 USART_IRQ_I,
  input  wire logic                 I2C_IRQ_I,
  input  wire logic                 NMI_SRC_I,
  // Interrupt lines to the nested_interrupt_controller
  output logic      [8:0]           IRQ_O,
  output logic                      NMI_O
);

  // ***************************************************************
  // Alias select
  // ***************************************************************
  logic alias_sel;

  // Write lands at the next edge; open data phases keep their target
  alias_sel_reg u_alias (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .wr_i    (ALIAS_WR_I),
    .val_i   (ALIAS_VAL_I),
    .sel_o   (alias_sel)
  );
  assign ALIAS_SEL_O = alias_sel;

  // ***************************************************************
  // Address decode
  // ***************************************************************
  logic        trans;
  logic        in_alias;
  logic [11:0] hit;
  logic        unmapped;

  assign trans    = HTRANS_I[1] && HREADY_I;
  assign in_alias = HADDR_I <= addr_map_pkg::ALIAS_LAST;

  // Each window compares against its own bounds
  assign hit[addr_map_pkg::SEL_FLASH] = (HADDR_I >= addr_map_pkg::FLASH_BASE
      && HADDR_I <= addr_map_pkg::FLASH_LAST)
      || (in_alias && !alias_sel);
  // SRAM alias covers only its 8 kB; the rest of the window errors
  assign hit[addr_map_pkg::SEL_SRAM] = (HADDR_I >= addr_map_pkg::SRAM_BASE
      && HADDR_I <= addr_map_pkg::SRAM_LAST)
      || (alias_sel && HADDR_I <= (addr_map_pkg::SRAM_LAST
      - addr_map_pkg::SRAM_BASE));
  assign hit[addr_map_pkg::SEL_SMU]  = HADDR_I >= addr_map_pkg::SMU_BASE
      && HADDR_I <= addr_map_pkg::SMU_LAST;
  assign hit[addr_map_pkg::SEL_FCTL] = HADDR_I >= addr_map_pkg::FCTL_BASE
      && HADDR_I <= addr_map_pkg::FCTL_LAST;
  assign hit[addr_map_pkg::SEL_INFO] = HADDR_I >= addr_map_pkg::INFO_BASE
      && HADDR_I <= addr_map_pkg::INFO_LAST;
  assign hit[addr_map_pkg::SEL_TMR]  = HADDR_I >= addr_map_pkg::TMR_BASE
      && HADDR_I <= addr_map_pkg::TMR_LAST;
  assign hit[addr_map_pkg::SEL_GPIO] = HADDR_I >= addr_map_pkg::GPIO_BASE
      && HADDR_I <= addr_map_pkg::GPIO_LAST;
  assign hit[addr_map_pkg::SEL_LIN]  = HADDR_I >= addr_map_pkg::LIN_BASE
      && HADDR_I <= addr_map_pkg::LIN_LAST;
  assign hit[addr_map_pkg::SEL_SER]  = HADDR_I >= addr_map_pkg::SER_BASE
      && HADDR_I <= addr_map_pkg::SER_LAST;
  assign hit[addr_map_pkg::SEL_SPI]  = HADDR_I >= addr_map_pkg::SPI_BASE
      && HADDR_I <= addr_map_pkg::SPI_LAST;
  assign hit[addr_map_pkg::SEL_PPB]  = HADDR_I >= addr_map_pkg::PPB_BASE
      && HADDR_I <= addr_map_pkg::PPB_LAST;
  assign hit[addr_map_pkg::SEL_ROM]  = HADDR_I >= addr_map_pkg::ROM_BASE
      && HADDR_I <= addr_map_pkg::ROM_LAST;

  assign SLV_SEL_O = trans ? hit : 12'h000;
  assign unmapped  = trans && (hit == 12'h000);

  logic [31:0] flash_alias_addr;
  logic [31:0] sram_alias_addr;

  // Alias keeps the offset, rebased onto the chosen memory; OR is safe
  // because both bases have zero bits across the whole window
  assign flash_alias_addr = addr_map_pkg::FLASH_BASE | HADDR_I;
  assign sram_alias_addr  = addr_map_pkg::SRAM_BASE | HADDR_I;
  assign SLV_ADDR_O = !in_alias ? HADDR_I
      : (alias_sel ? sram_alias_addr : flash_alias_addr);

  // ***************************************************************
  // Data phase tracking
  // ***************************************************************
  logic [11:0] dsel_reg;
  logic        ds_ready;
  logic        ds_err;

  // Registered select steers the answer mux
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dsel_reg <= 12'h000;
    end else if (CE_I && HREADY_I) begin
      dsel_reg <= SLV_SEL_O;
    end
  end

  resp_slave u_default (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .sel_i   (unmapped),
    .ready_i (HREADY_I),
    .ready_o (ds_ready),
    .err_o   (ds_err)
  );

  // ***************************************************************
  // Answer mux
  // ***************************************************************
  logic        mux_ready;
  logic        mux_resp;
  logic [31:0] mux_data;

  // One-hot select, so a loop where the last hit wins is enough
  always_comb begin
    mux_ready = ds_ready;
    mux_resp  = ds_err;
    mux_data  = 32'h0000_0000;
    for (int i = 0; i < addr_map_pkg::NUM_SLV; i++) begin
      if (dsel_reg[i]) begin
        mux_ready = SLV_READY_I[i];
        mux_resp  = SLV_RESP_I[i];
        mux_data  = SLV_RDATA_I[i];
      end
    end
  end

  assign HREADY_O = mux_ready;
  assign HRESP_O  = mux_resp;
  assign HRDATA_O = mux_data;

  // ***************************************************************
  // Interrupt routing
  // ***************************************************************
  // Pure wiring; sources are already on this clock
  assign IRQ_O[addr_map_pkg::IRQ_FLASH] = FLASH_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_EXT]   = SBC_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_LIN]   = LIN_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_SPI]   = SPI_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_TMR]   = TMR_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_GPIO]  = GPIO_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_SSPI]  = SSPI_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_USART] = USART_IRQ_I;
  assign IRQ_O[addr_map_pkg::IRQ_I2C]   = I2C_IRQ_I;
  assign NMI_O = NMI_SRC_I;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  sequence err_first;
    trans && unmapped && CE_I;
  endsequence
  sequence err_pair;
    (!HREADY_O && HRESP_O) ##1 (HREADY_O && HRESP_O);
  endsequence

  // Unmapped access gets a stall cycle, then the closing error cycle
  default_err_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    err_first |=> err_pair)
    else $error("unmapped access lacks error answer");

  // Whole low window lands on flash while the alias is clear
  alias_flash_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && in_alias && !alias_sel)
      |-> SLV_SEL_O[addr_map_pkg::SEL_FLASH])
    else $error("alias 0 not flash");

  // Base of the low window lands on SRAM once the alias is set
  alias_sram_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && alias_sel && HADDR_I == addr_map_pkg::ALIAS_BASE)
      |-> SLV_SEL_O[addr_map_pkg::SEL_SRAM])
    else $error("alias 1 not sram");

  // SRAM alias is only 8 kB deep; the byte after it must error
  sram_alias_end_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && alias_sel && HADDR_I == addr_map_pkg::SRAM_LAST
      - addr_map_pkg::SRAM_BASE + 32'h0000_0001) |-> unmapped)
    else $error("sram alias too large");

  // A write strobe loads the new select at the next edge
  alias_write_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (CE_I && ALIAS_WR_I) |=> ALIAS_SEL_O == $past(ALIAS_VAL_I))
    else $error("alias write lost");

  // Fresh out of reset the select shows flash at zero
  reset_alias_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $rose(RST_N_I) |-> ALIAS_SEL_O == addr_map_pkg::ALIAS_RST)
    else $error("alias not cleared by reset");

  // Without a strobe the select never moves
  alias_hold_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    !ALIAS_WR_I |=> $stable(ALIAS_SEL_O))
    else $error("alias changed without write");

  // A stalled data phase keeps the slave it started with
  dsel_hold_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (CE_I && !HREADY_I) |=> $stable(dsel_reg))
    else $error("data phase target moved");

  // Rebasing never disturbs the offset inside the window
  alias_offset_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    in_alias |-> SLV_ADDR_O[16:0] == HADDR_I[16:0])
    else $error("alias offset changed");

  // Private peripheral bus owns its whole megabyte
  ppb_route_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && HADDR_I[31:20] == addr_map_pkg::PPB_BASE[31:20])
      |-> SLV_SEL_O == (12'h001 << addr_map_pkg::SEL_PPB))
    else $error("ppb not routed");

  // First byte past the private bus is unmapped
  ppb_end_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && HADDR_I == addr_map_pkg::PPB_LAST + 32'h0000_0001) |-> unmapped)
    else $error("ppb window too large");

  // Serial group answers for its whole window
  ser_route_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && HADDR_I[31:10] == addr_map_pkg::SER_BASE[31:10])
      |-> SLV_SEL_O == (12'h001 << addr_map_pkg::SEL_SER))
    else $error("serial group not routed");

  // First byte past the 96 kB flash is unmapped
  flash_end_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && HADDR_I == addr_map_pkg::FLASH_LAST + 32'h0000_0001)
      |-> unmapped)
    else $error("flash window too large");

  // First byte past the 8 kB SRAM is unmapped
  sram_size_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (trans && HADDR_I == addr_map_pkg::SRAM_LAST + 32'h0000_0001)
      |-> unmapped)
    else $error("sram window too large");

  // Windows never overlap, so at most one slave is picked
  sel_onehot_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $onehot0(SLV_SEL_O))
    else $error("two slaves selected");

  // Fixed lines for flash, external and timer requests
  irq_map_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    IRQ_O[addr_map_pkg::IRQ_FLASH] == FLASH_IRQ_I
    && IRQ_O[addr_map_pkg::IRQ_EXT] == SBC_IRQ_I
    && IRQ_O[addr_map_pkg::IRQ_TMR] == TMR_IRQ_I)
    else $error("irq lines misrouted");

  // Non-maskable request passes straight through
  nmi_route_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    NMI_O == NMI_SRC_I)
    else $error("nmi misrouted");

endmodule : mcu_address_decoder

`default_nettype wire

/* rtl/addr_map_pkg.sv */
`default_nettype none

package addr_map_pkg;

  // ***************************************************************
  // Address map
  // ***************************************************************
  localparam logic [31:0] ALIAS_BASE   = 32'h0000_0000;
  localparam logic [31:0] ALIAS_LAST   = 32'h0001_7FFF;
  localparam logic [31:0] FLASH_BASE   = 32'h1000_0000;
  localparam logic [31:0] FLASH_LAST   = 32'h1001_7FFF;
  localparam logic [31:0] SRAM_BASE    = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST    = 32'h2000_1FFF;
  localparam logic [31:0] SMU_BASE     = 32'h4000_0000;
  localparam logic [31:0] SMU_LAST     = 32'h4000_03FF;
  localparam logic [31:0] FCTL_BASE    = 32'h4000_0800;
  localparam logic [31:0] FCTL_LAST    = 32'h4000_0BFF;
  localparam logic [31:0] INFO_BASE    = 32'h4000_0C00;
  localparam logic [31:0] INFO_LAST    = 32'h4000_0FFF;
  localparam logic [31:0] TMR_BASE     = 32'h4000_1000;
  localparam logic [31:0] TMR_LAST     = 32'h4000_13FF;
  localparam logic [31:0] GPIO_BASE    = 32'h4000_1400;
  localparam logic [31:0] GPIO_LAST    = 32'h4000_17FF;
  localparam logic [31:0] LIN_BASE     = 32'h4000_1800;
  localparam logic [31:0] LIN_LAST     = 32'h4000_1BFF;
  localparam logic [31:0] SER_BASE     = 32'h4000_1C00;
  localparam logic [31:0] SER_LAST     = 32'h4000_1FFF;
  localparam logic [31:0] SPI_BASE     = 32'h4000_2000;
  localparam logic [31:0] SPI_LAST     = 32'h4000_23FF;
  localparam logic [31:0] PPB_BASE     = 32'hE000_0000;
  localparam logic [31:0] PPB_LAST     = 32'hE00F_FFFF;
  localparam logic [31:0] ROM_BASE     = 32'hF000_0000;
  localparam logic [31:0] ROM_LAST     = 32'hF000_0FFF;

  // ***************************************************************
  // Slave select indices
  // ***************************************************************
  localparam int NUM_SLV  = 12;
  localparam int SEL_FLASH = 0;
  localparam int SEL_SRAM  = 1;
  localparam int SEL_SMU   = 2;
  localparam int SEL_FCTL  = 3;
  localparam int SEL_INFO  = 4;
  localparam int SEL_TMR   = 5;
  localparam int SEL_GPIO  = 6;
  localparam int SEL_LIN   = 7;
  localparam int SEL_SER   = 8;
  localparam int SEL_SPI   = 9;
  localparam int SEL_PPB   = 10;
  localparam int SEL_ROM   = 11;

  // ***************************************************************
  // Interrupt lines
  // ***************************************************************
  localparam int NUM_IRQ   = 9;
  localparam int IRQ_FLASH = 0;
  localparam int IRQ_EXT   = 1;
  localparam int IRQ_LIN   = 2;
  localparam int IRQ_SPI   = 3;
  localparam int IRQ_TMR   = 4;
  localparam int IRQ_GPIO  = 5;
  localparam int IRQ_SSPI  = 6;
  localparam int IRQ_USART = 7;
  localparam int IRQ_I2C   = 8;

  // ***************************************************************
  // Alias select reset value and AHB codes
  // ***************************************************************
  localparam logic       ALIAS_RST  = 1'b0;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HRESP_OKAY  = 2'h0;
  localparam logic       HRESP_ERR   = 1'b1;

endpackage : addr_map_pkg

`default_nettype wire

/* rtl/alias_sel_reg.sv */
`timescale 1ns/1ps
`default_nettype none

// Holds the alias select bit; a strobe loads it at the next enabled
// edge. Open data phases keep their target since the select is registered.
module alias_sel_reg (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Control
  input  wire logic wr_i,
  input  wire logic val_i,
  // State
  output logic      sel_o
);

  logic sel_reg;

  // Reset value puts flash at zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_reg <= addr_map_pkg::ALIAS_RST;
    end else if (ce_i && wr_i) begin
      sel_reg <= val_i;
    end
  end

  assign sel_o = sel_reg;

endmodule : alias_sel_reg

`default_nettype wire

/* rtl/resp_slave.sv */
`timescale 1ns/1ps
`default_nettype none

// Default slave: two-cycle error answer for unmapped accesses.
module resp_slave (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Address phase
  input  wire logic sel_i,
  input  wire logic ready_i,
  // Answer
  output logic      ready_o,
  output logic      err_o
);

  logic first_reg;
  logic second_reg;

  // First cycle holds ready low, second ends it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_reg  <= 1'b0;
      second_reg <= 1'b0;
    end else if (ce_i) begin
      first_reg  <= sel_i && ready_i && !first_reg;
      second_reg <= first_reg;
    end
  end

  assign ready_o = !first_reg;
  assign err_o   = first_reg || second_reg;

endmodule : resp_slave

`default_nettype wire

/* tb/slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Memories and peripherals behind the decoder. Only the data-phase owner
// stalls; released slaves show inverted data so stale values never match.
module slave_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Address phase seen by the slaves
  input  wire logic [11:0] sel_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hready_i,
  input  wire logic [3:0]  waits_i,
  // Answers
  output logic      [11:0] ready_o,
  output logic      [11:0] resp_o,
  output logic      [31:0] rdata_o [12]
);
  logic [11:0] act_reg;
  logic [3:0]  cnt_reg;

  // Owner of the data phase and its remaining wait states
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_reg <= 12'h000;
      cnt_reg <= 4'h0;
    end else if (hready_i) begin
      act_reg <= htrans_i[1] ? sel_i : 12'h000;
      cnt_reg <= waits_i;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // Slow or prompt answer, always okay when it comes
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      ready_o[i] = !(act_reg[i] && cnt_reg != 4'h0);
      resp_o[i]  = 1'b0;
      rdata_o[i] = 32'h5A5A_0000 + 32'(i);
      if (!(act_reg[i] && cnt_reg == 4'h0)) begin
        rdata_o[i] = ~rdata_o[i];
      end
    end
  end
endmodule : slave_model

`default_nettype wire

/* tb/mcu_address_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module mcu_address_decoder_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        alias_wr = 1'b0;
  logic        alias_val = 1'b0;
  logic [3:0]  waits = 4'h0;
  logic [9:0]  src = 10'h000;
  logic        al = 1'b0;
  logic        ce = 1'b1;
  int          err_total = 0;
  int          compares = 0;
  wire  [11:0] sel;
  wire  [31:0] saddr;
  wire         hready;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         alias_sel;
  wire  [8:0]  irq;
  wire         nmi;
  wire  [11:0] s_ready;
  wire  [11:0] s_resp;
  wire  [31:0] s_rdata [12];
  logic [31:0] bt [12] = '{addr_map_pkg::FLASH_BASE, addr_map_pkg::SRAM_BASE,
    addr_map_pkg::SMU_BASE, addr_map_pkg::FCTL_BASE, addr_map_pkg::INFO_BASE,
    addr_map_pkg::TMR_BASE, addr_map_pkg::GPIO_BASE, addr_map_pkg::LIN_BASE,
    addr_map_pkg::SER_BASE, addr_map_pkg::SPI_BASE, addr_map_pkg::PPB_BASE,
    addr_map_pkg::ROM_BASE};
  logic [31:0] lt [12] = '{addr_map_pkg::FLASH_LAST, addr_map_pkg::SRAM_LAST,
    addr_map_pkg::SMU_LAST, addr_map_pkg::FCTL_LAST, addr_map_pkg::INFO_LAST,
    addr_map_pkg::TMR_LAST, addr_map_pkg::GPIO_LAST, addr_map_pkg::LIN_LAST,
    addr_map_pkg::SER_LAST, addr_map_pkg::SPI_LAST, addr_map_pkg::PPB_LAST,
    addr_map_pkg::ROM_LAST};

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // Master sees its own ready fed back, as on a single-master bus
  mcu_address_decoder dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HREADY_I(hready),
    .ALIAS_WR_I(alias_wr), .ALIAS_VAL_I(alias_val),
    .SLV_READY_I(s_ready), .SLV_RESP_I(s_resp), .SLV_RDATA_I(s_rdata),
    .SLV_SEL_O(sel), .SLV_ADDR_O(saddr), .HREADY_O(hready),
    .HRESP_O(hresp), .HRDATA_O(hrdata), .ALIAS_SEL_O(alias_sel),
    .FLASH_IRQ_I(src[0]), .SBC_IRQ_I(src[1]), .LIN_IRQ_I(src[2]),
    .SPI_IRQ_I(src[3]), .TMR_IRQ_I(src[4]), .GPIO_IRQ_I(src[5]),
    .SSPI_IRQ_I(src[6]), .USART_IRQ_I(src[7]), .I2C_IRQ_I(src[8]),
    .NMI_SRC_I(src[9]), .IRQ_O(irq), .NMI_O(nmi));

  slave_model slv_u (
    .clk_i(clk), .rst_n_i(rst_n), .sel_i(sel), .htrans_i(htrans),
    .hready_i(hready), .waits_i(waits), .ready_o(s_ready),
    .resp_o(s_resp), .rdata_o(s_rdata));

  // Expected one-hot select; SRAM alias only covers its own 8 kB
  function automatic logic [11:0] exp_sel(input logic [31:0] a);
    logic [11:0] s;
    s = 12'h000;
    if (a <= addr_map_pkg::ALIAS_LAST) begin
      if (!al) s[0] = 1'b1;
      else if (a <= 32'h0000_1FFF) s[1] = 1'b1;
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (a >= bt[i] && a <= lt[i]) s[i] = 1'b1;
      end
    end
    return s;
  endfunction : exp_sel

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask : chk

  task automatic give_verdict();
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // One transfer: address phase, then data phase until ready
  task automatic acc(input logic [31:0] a);
    logic [11:0] es;
    logic [31:0] ea;
    int          n;
    int          k;
    es = exp_sel(a);
    ea = a;
    k = 0;
    if (a <= addr_map_pkg::ALIAS_LAST) ea = (al ? bt[1] : bt[0]) + a;
    for (int i = 0; i < 12; i++) if (es[i]) k = i;
    @(posedge clk);
    haddr <= a;
    htrans <= 2'h2;
    waits <= 4'($urandom % 4);
    #1;
    chk(32'(sel), 32'(es));
    if (es != 12'h000) chk(saddr, ea);
    @(posedge clk);
    htrans <= 2'h0;
    #1;
    if (es == 12'h000) begin
      chk(32'({hready, hresp}), 32'h0000_0001);
      @(posedge clk);
      #1;
      chk(32'({hready, hresp}), 32'h0000_0003);
    end else begin
      n = 0;
      while (hready !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (hready !== 1'b1) begin
        err_total++;
        give_verdict();
      end
      chk(hrdata, 32'h5A5A_0000 + 32'(k));
      chk(32'(hresp), 32'h0000_0000);
    end
  endtask : acc

  // Alias select write, visible one edge later
  task automatic set_alias(input logic v);
    @(posedge clk);
    alias_wr <= 1'b1;
    alias_val <= v;
    @(posedge clk);
    alias_wr <= 1'b0;
    #1;
    chk(32'(alias_sel), 32'(v));
    al = v;
  endtask : set_alias

  // Corner cases first, then random traffic and interrupt sources
  initial begin
    int s;
    int i;
    s = $urandom(32'h0000_F650);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(32'(alias_sel), 32'h0000_0000);
    acc(32'h0000_0040);
    for (int j = 0; j < 12; j++) begin
      acc(bt[j]);
      acc(lt[j]);
      acc(lt[j] + 32'h0000_0001);
    end
    for (int v = 1; v >= 0; v--) begin
      set_alias(v[0]);
      acc(32'h0000_0000);
      acc(32'h0000_1FFF);
      acc(32'h0000_2000);
      acc(addr_map_pkg::ALIAS_LAST);
      acc(addr_map_pkg::ALIAS_LAST + 32'h0000_0001);
    end
    // Mid-run reset must drop a set alias back to flash
    set_alias(1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    al = 1'b0;
    #1;
    chk(32'(alias_sel), 32'h0000_0000);
    // Frozen enable must ignore a write strobe
    @(posedge clk);
    ce <= 1'b0;
    alias_wr <= 1'b1;
    alias_val <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    alias_wr <= 1'b0;
    #1;
    chk(32'(alias_sel), 32'h0000_0000);
    acc(32'h0000_0040);
    repeat (300) begin
      if ($urandom % 16 == 0) set_alias(1'($urandom));
      i = $urandom % 12;
      acc(bt[i] + ($urandom % (lt[i] - bt[i] + 32'h0000_0001)));
      acc($urandom);
    end
    repeat (60) begin
      @(posedge clk);
      src <= 10'($urandom);
      #1;
      chk(32'(irq), 32'(src[8:0]));
      chk(32'(nmi), 32'(src[9]));
    end
    give_verdict();
  end
endmodule : mcu_address_decoder_tb

`default_nettype wire
